// [design/esp_pkg.sv]
// Constants and types shared by the encoder serial position port
`default_nettype none
package esp_pkg;
    // Byte-mode operation codes
    localparam logic [7:0] OP_REG_READ = 8'h81;
    localparam logic [7:0] OP_REG_WRITE = 8'hCF;
    localparam logic [7:0] OP_POS_READ = 8'hA6;
    // 24-bit framing: address that returns position
    localparam logic [7:0] POS_ADDR = 8'h3F;
    // Frame format select codes
    localparam logic [1:0] FMT_SPI24 = 2'b10;
    localparam logic [1:0] FMT_SPI8 = 2'b11;
    // Frame geometry
    localparam int POS_MAX_BITS = 18;
    localparam int FLAG_BITS = 2;
    localparam int CRC8_BITS = 8;
    localparam int SPI24_FRAME_BITS = 24;
    localparam int CRC_IN_BITS = 24;
    localparam logic [4:0] SPI24_WIDE_RES = 5'h0F;
    localparam logic [4:0] BYTE3_RES = 5'h11;
    // Checksums
    localparam logic [7:0] CRC8_POLY = 8'h1D;
    localparam logic [15:0] CRC16_POLY = 16'h1021;
    // Sequence counter range
    localparam logic [7:0] SEQ_FIRST = 8'h01;
    localparam logic [7:0] SEQ_LAST = 8'hFF;
    // Reset values
    localparam logic [7:0] ADDR_RESET = 8'h00;

    // Sensor status byte, ready pair on top
    typedef struct packed {
        logic [1:0] ready;
        logic magnet_too_strong;
        logic magnet_too_weak;
        logic supply_over_limit;
        logic supply_under_limit;
        logic memory_fault;
        logic tracking_fault;
    } esp_status_type;

    // Register write request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } esp_wr_type;

    // Pins after synchronising
    typedef struct packed {
        logic family;
        logic strap;
        logic strobe;
        logic sclk;
        logic sdi;
    } esp_pins_type;

    typedef enum logic [3:0] {
        MODE_OFF = 4'b0001,
        MODE_SPI24 = 4'b0010,
        MODE_SPI8 = 4'b0100,
        MODE_SSI3 = 4'b1000
    } esp_mode_type;

    typedef enum logic [6:0] {
        ST_OPCODE = 7'b0000001,
        ST_RADDR = 7'b0000010,
        ST_RDATA = 7'b0000100,
        ST_WADDR = 7'b0001000,
        ST_WDATA = 7'b0010000,
        ST_POS = 7'b0100000,
        ST_IGNORE = 7'b1000000
    } esp_byte_state_type;
endpackage
`default_nettype wire

// [design/esp_port.sv]
// Encoder serial position port: 24-bit CRC SPI, byte SPI and 3-wire SSI
//
// What this block does
// - 24-bit CRC framing when variant select 0 and frame format is 2'b10.
// - Every 24-bit reply starts with warning then error, payload padded, then CRC.
// - A 24-bit read of address 0x3F returns the position reply.
// - From 15-bit resolution the frames grow one bit per extra position bit.
// - CRC covers 16 data bits, or data padded to 24 bits when longer.
// - Byte SPI when variant select 0 and both frame format bits are 1.
// - Byte SPI is active only with chip select low; input sampled on rise.
// - Serial output is high impedance while chip select is high.
// - Opcode 0x81 reads successive registers while clocking continues.
// - Opcode 0xCF writes successive registers, address rising by one.
// - Written data bytes are echoed back on the serial output.
// - Opcode 0xA6 returns position bytes sized by resolution, then status.
// - Safety format adds sequence counter byte and CRC bytes.
// - Sequence counter steps 1 to 255 per position reply; CRC polys 0x1D, 0x1021.
// - 3-wire pins: frame strobe in, serial clock in, serial data out.
// - Variant 0 drives 3-wire output high while strobe is high.
// - Variant 1 releases 3-wire output while strobe is high.
// - 3-wire frame: position MSB first, seven status bits, parity.
// - The 3-wire trailing parity bit is even parity.
`default_nettype none
module esp_port (
    // Clock, reset, enable
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_ce,
    // Serial pins
    input wire logic i_frame_strobe_pin,
    input wire logic i_serial_clock_pin,
    input wire logic i_serial_input_pin,
    output logic o_serial_output_pin,
    output logic o_serial_output_oe_n,
    // Straps and configuration
    input wire logic i_interface_family_select_pin,
    input wire logic i_mode_strap_pin,
    input wire logic i_protocol_variant_select,
    input wire logic [1:0] i_spi_frame_format_select,
    input wire logic [4:0] i_resolution,
    input wire logic i_safety_format,
    input wire logic i_crc16_select,
    input wire logic [15:0] i_crc_init,
    input wire logic [7:0] i_seq_init,
    // Sensor data
    input wire logic [17:0] i_position,
    input wire esp_pkg::esp_status_type i_status,
    input wire logic i_warning,
    input wire logic i_error,
    // Register file access
    output logic [7:0] o_rd_addr,
    input wire logic [7:0] i_rd_data,
    output logic o_wr_valid,
    output esp_pkg::esp_wr_type o_wr,
    input wire logic i_wr_ready,
    output logic o_wr_overflow,
    input wire logic i_overflow_clear
);
    import esp_pkg::*;

    // Bitwise CRC over the top len bits of msg; 8-bit CRC runs in the upper byte
    function automatic logic [15:0] esp_crc(input logic [63:0] msg, input logic [6:0] len,
                                            input logic wide, input logic [15:0] init);
        logic [15:0] c;
        logic fb;
        int i;
        c = wide ? init : {init[7:0], 8'h00};
        for (i = 0; i < 64; i++)
        begin
            if (i < int'(len))
            begin
                fb = c[15] ^ msg[63 - i];
                c = {c[14:0], 1'b0};
                if (fb)
                    c = c ^ (wide ? CRC16_POLY : {CRC8_POLY, 8'h00});
            end
        end
        return wide ? c : {8'h00, c[15:8]};
    endfunction

    esp_pins_type pins_raw, sync1, sync2, prev, next_sync1, next_sync2, next_prev;
    esp_mode_type mode;
    esp_byte_state_type byte_st, next_byte_st;
    logic [63:0] tx_sr, next_tx_sr, spi24_tx, pos_tx, ssi_tx, pos_msg;
    logic [31:0] rx_sr, next_rx_sr;
    logic [5:0] bit_cnt, next_bit_cnt, frame_len, d_len;
    logic [7:0] rd_addr, next_rd_addr, seq, next_seq, pend_data, next_pend_data, rx_byte, mem_byte;
    logic [7:0] crc24, rx_crc;
    logic [15:0] pos_crc, crc_al;
    logic [6:0] crc24_len, pos_crc_len;
    logic [17:0] pos_al;
    logic [23:0] data24, rx_data24;
    logic rd_pend, next_rd_pend, seq_armed, next_seq_armed, pend_pos, next_pend_pos;
    logic pend_echo, next_pend_echo, out, next_out, oe_n, next_oe_n, wide, byte3, parity;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, push;
    esp_wr_type push_word, head, spare, next_head, next_spare;
    logic head_v, spare_v, next_head_v, next_spare_v, ovf, next_ovf;

    // Every pin crosses two flops before any logic looks at it
    assign pins_raw = '{family: i_interface_family_select_pin, strap: i_mode_strap_pin,
                        strobe: i_frame_strobe_pin, sclk: i_serial_clock_pin,
                        sdi: i_serial_input_pin};
    always_comb
    begin
        next_sync1 = pins_raw;
        next_sync2 = sync1;
        next_prev = sync2;
    end
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            sync1 <= '{family: 1'b0, strap: 1'b0, strobe: 1'b1, sclk: 1'b1, sdi: 1'b0};
            sync2 <= '{family: 1'b0, strap: 1'b0, strobe: 1'b1, sclk: 1'b1, sdi: 1'b0};
            prev <= '{family: 1'b0, strap: 1'b0, strobe: 1'b1, sclk: 1'b1, sdi: 1'b0};
        end
        else if (i_ce)
        begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev <= next_prev;
        end
    end

    // Edges seen on the link clock and the frame strobe
    assign sclk_rise = sync2.sclk & ~prev.sclk;
    assign sclk_fall = ~sync2.sclk & prev.sclk;
    assign cs_fall = ~sync2.strobe & prev.strobe;
    assign cs_rise = sync2.strobe & ~prev.strobe;

    // Link style from straps and configuration
    always_comb
    begin
        if (!sync2.family && sync2.strap)
            mode = MODE_SSI3;
        else if (sync2.family && !i_protocol_variant_select &&
                 i_spi_frame_format_select == FMT_SPI24)
            mode = MODE_SPI24;
        else if (sync2.family && !i_protocol_variant_select &&
                 i_spi_frame_format_select == FMT_SPI8)
            mode = MODE_SPI8;
        else
            mode = MODE_OFF;
    end

    // Frame geometry; long resolutions stretch the 24-bit frame
    assign wide = i_resolution >= SPI24_WIDE_RES;
    assign frame_len = wide ? 6'(i_resolution) + 6'(FLAG_BITS + CRC8_BITS)
                            : 6'(SPI24_FRAME_BITS);
    assign d_len = frame_len - 6'(CRC8_BITS);
    assign crc24_len = wide ? 7'(CRC_IN_BITS) : 7'(SPI24_FRAME_BITS - CRC8_BITS);
    assign pos_al = 18'(i_position << (5'(POS_MAX_BITS) - i_resolution));

    // 24-bit reply: flags, payload left aligned, CRC right behind the data
    assign mem_byte = pend_echo ? pend_data : i_rd_data;
    assign data24 = pend_pos ? {i_warning, i_error, pos_al, 4'h0}
                             : {i_warning, i_error, 6'h00, mem_byte, 8'h00};
    assign crc24 = 8'(esp_crc({data24, 40'h0}, crc24_len, 1'b0, i_crc_init));
    assign spi24_tx = {data24, 40'h0} | ({crc24, 56'h0} >> d_len);

    // Command check: data bits lifted to the top, CRC compared before use
    assign rx_data24 = 24'(rx_sr[31:8] << (6'(SPI24_FRAME_BITS) - d_len));
    assign rx_crc = 8'(esp_crc({rx_data24, 40'h0}, crc24_len, 1'b0, i_crc_init));

    // Byte-mode position reply, two or three position bytes
    assign byte3 = i_resolution >= BYTE3_RES;
    assign pos_msg = byte3 ? {pos_al, 6'h00, i_status, seq, 24'h0}
                           : {pos_al[17:2], i_status, seq, 32'h0};
    assign pos_crc_len = byte3 ? 7'h28 : 7'h20;
    assign pos_crc = esp_crc(pos_msg, pos_crc_len, i_crc16_select, i_crc_init);
    assign crc_al = i_crc16_select ? pos_crc : {pos_crc[7:0], 8'h00};
    assign pos_tx = i_safety_format ? pos_msg | ({crc_al, 48'h0} >> pos_crc_len)
                  : (byte3 ? {pos_al, 6'h00, i_status, 32'h0}
                           : {pos_al[17:2], i_status, 40'h0});

    // 3-wire frame: position, seven status bits, even parity
    assign parity = ^{pos_al, i_status.ready[1], i_status[5:0]};
    assign ssi_tx = {pos_al, 46'h0} |
                    ({i_status.ready[1], i_status[5:0], parity, 56'h0} >> i_resolution);

    assign rx_byte = {rx_sr[6:0], sync2.sdi};

    // Link engine: shift, decode, and steer the output driver
    always_comb
    begin
        next_tx_sr = tx_sr;
        next_rx_sr = rx_sr;
        next_bit_cnt = bit_cnt;
        next_byte_st = byte_st;
        next_rd_addr = rd_addr;
        next_rd_pend = 1'b0;
        next_seq = seq;
        next_seq_armed = seq_armed;
        next_pend_pos = pend_pos;
        next_pend_echo = pend_echo;
        next_pend_data = pend_data;
        next_out = out;
        next_oe_n = oe_n;
        push = 1'b0;
        push_word = '{addr: rd_addr, data: rx_byte};
        // Power-up value of the counter is caught once after reset
        if (!seq_armed)
        begin
            next_seq = i_seq_init;
            next_seq_armed = 1'b1;
        end
        if (sync2.strobe)
        begin
            // Only variant 0 of the 3-wire link keeps driving between frames
            next_oe_n = !(mode == MODE_SSI3 && !i_protocol_variant_select);
            next_out = 1'b1;
        end
        if (cs_fall)
        begin
            next_bit_cnt = 6'h00;
            next_rx_sr = 32'h0;
            next_byte_st = ST_OPCODE;
            next_oe_n = (mode == MODE_OFF);
            if (mode == MODE_SPI24)
            begin
                // First bit is presented before the first clock edge
                next_out = spi24_tx[63];
                next_tx_sr = spi24_tx << 1;
            end
            else if (mode == MODE_SSI3)
            begin
                // MSB appears on the first falling clock edge
                next_out = 1'b1;
                next_tx_sr = ssi_tx;
            end
            else
            begin
                next_out = 1'b0;
                next_tx_sr = 64'h0;
            end
        end
        else if (!sync2.strobe && mode != MODE_OFF)
        begin
            if (sclk_fall)
            begin
                next_out = tx_sr[63];
                next_tx_sr = tx_sr << 1;
            end
            if (rd_pend)
                next_tx_sr = {i_rd_data, 56'h0};
            if (sclk_rise)
            begin
                next_rx_sr = {rx_sr[30:0], sync2.sdi};
                next_bit_cnt = bit_cnt + 6'h01;
                if (mode == MODE_SPI8 && bit_cnt[2:0] == 3'h7)
                begin
                    unique case (byte_st)
                        ST_OPCODE:
                        begin
                            if (rx_byte == OP_REG_READ)
                                next_byte_st = ST_RADDR;
                            else if (rx_byte == OP_REG_WRITE)
                                next_byte_st = ST_WADDR;
                            else if (rx_byte == OP_POS_READ)
                            begin
                                next_byte_st = ST_POS;
                                next_tx_sr = pos_tx;
                                if (i_safety_format)
                                    next_seq = (seq == SEQ_LAST) ? SEQ_FIRST : seq + 8'h01;
                            end
                            else
                                next_byte_st = ST_IGNORE;
                        end
                        ST_RADDR:
                        begin
                            next_rd_addr = rx_byte;
                            next_rd_pend = 1'b1;
                            next_byte_st = ST_RDATA;
                        end
                        ST_RDATA:
                        begin
                            next_rd_addr = rd_addr + 8'h01;
                            next_rd_pend = 1'b1;
                        end
                        ST_WADDR:
                        begin
                            next_rd_addr = rx_byte;
                            next_byte_st = ST_WDATA;
                        end
                        ST_WDATA:
                        begin
                            push = 1'b1;
                            next_rd_addr = rd_addr + 8'h01;
                            next_tx_sr = {rx_byte, 56'h0};
                        end
                        ST_POS, ST_IGNORE:
                        begin
                            next_byte_st = byte_st;
                        end
                    endcase
                end
            end
        end
        // Whole 24-bit command is judged at the strobe's rise
        if (cs_rise && mode == MODE_SPI24 && bit_cnt == frame_len &&
            rx_crc == rx_sr[7:0] && !rx_data24[23])
        begin
            if (rx_data24[22])
            begin
                next_rd_addr = rx_sr[15:8];
                next_pend_pos = (rx_sr[15:8] == POS_ADDR);
                next_pend_echo = 1'b0;
            end
            else
            begin
                push = 1'b1;
                push_word = '{addr: rd_addr, data: rx_sr[15:8]};
                next_pend_pos = 1'b0;
                next_pend_echo = 1'b1;
                next_pend_data = rx_sr[15:8];
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            tx_sr <= 64'h0;
            rx_sr <= 32'h0;
            bit_cnt <= 6'h00;
            byte_st <= ST_IGNORE;
            rd_addr <= ADDR_RESET;
            rd_pend <= 1'b0;
            seq <= SEQ_FIRST;
            seq_armed <= 1'b0;
            pend_pos <= 1'b1;
            pend_echo <= 1'b0;
            pend_data <= 8'h00;
            out <= 1'b1;
            oe_n <= 1'b1;
        end
        else if (i_ce)
        begin
            tx_sr <= next_tx_sr;
            rx_sr <= next_rx_sr;
            bit_cnt <= next_bit_cnt;
            byte_st <= next_byte_st;
            rd_addr <= next_rd_addr;
            rd_pend <= next_rd_pend;
            seq <= next_seq;
            seq_armed <= next_seq_armed;
            pend_pos <= next_pend_pos;
            pend_echo <= next_pend_echo;
            pend_data <= next_pend_data;
            out <= next_out;
            oe_n <= next_oe_n;
        end
    end

    // Two-entry write buffer; the link cannot be stalled, so a third
    // pending write is dropped and flagged rather than lost silently
    always_comb
    begin
        next_head = head;
        next_head_v = head_v;
        next_spare = spare;
        next_spare_v = spare_v;
        next_ovf = ovf & ~i_overflow_clear;
        if (head_v && i_wr_ready)
        begin
            next_head = spare;
            next_head_v = spare_v;
            next_spare_v = 1'b0;
        end
        if (push)
        begin
            if (!next_head_v)
            begin
                next_head = push_word;
                next_head_v = 1'b1;
            end
            else if (!next_spare_v)
            begin
                next_spare = push_word;
                next_spare_v = 1'b1;
            end
            else
                next_ovf = 1'b1; // Set wins over clear
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            head <= '{addr: 8'h00, data: 8'h00};
            spare <= '{addr: 8'h00, data: 8'h00};
            head_v <= 1'b0;
            spare_v <= 1'b0;
            ovf <= 1'b0;
        end
        else if (i_ce)
        begin
            head <= next_head;
            spare <= next_spare;
            head_v <= next_head_v;
            spare_v <= next_spare_v;
            ovf <= next_ovf;
        end
    end

    // Outputs straight from flops
    assign o_serial_output_pin = out;
    assign o_serial_output_oe_n = oe_n;
    assign o_rd_addr = rd_addr;
    assign o_wr_valid = head_v;
    assign o_wr = head;
    assign o_wr_overflow = ovf;
endmodule // esp_port
`default_nettype wire

// [tb/esp_port_chk_sva.sv]
// Checker for the encoder serial position port, bound to its top module
`default_nettype none
module esp_port_chk import esp_pkg::*; (
    // Clock, reset, enable
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_ce,
    // Pins and straps
    input wire logic i_frame_strobe_pin,
    input wire logic i_interface_family_select_pin,
    input wire logic i_mode_strap_pin,
    input wire logic i_protocol_variant_select,
    input wire logic o_serial_output_pin,
    input wire logic o_serial_output_oe_n,
    // Register file side
    input wire logic [7:0] o_rd_addr,
    input wire logic o_wr_valid,
    input wire esp_pkg::esp_wr_type o_wr,
    input wire logic i_wr_ready,
    input wire logic o_wr_overflow,
    input wire logic i_overflow_clear
);
    // One clock domain; reset aborts every attempt in flight
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    // Idle strobe per family; clock enable kept in so a frozen port never trips them
    wire logic spi_idle = i_interface_family_select_pin && i_frame_strobe_pin && i_ce;
    wire logic ssi_idle = !i_interface_family_select_pin && i_mode_strap_pin
        && i_frame_strobe_pin && i_ce;

    a_reset_values: assert property ($fell(i_srst) && $past(i_ce) |-> o_serial_output_oe_n
        && o_serial_output_pin && !o_wr_valid && !o_wr_overflow && o_rd_addr == ADDR_RESET)
        else $error("outputs not at reset values after reset");
    a_spi_idle_hiz: assert property (spi_idle [*6] |=> o_serial_output_oe_n)
        else $error("serial output driven while chip select high");
    a_ssi_idle_high: assert property ((ssi_idle && !i_protocol_variant_select) [*8]
        |=> !o_serial_output_oe_n && o_serial_output_pin)
        else $error("three-wire idle output not driven high");
    a_ssi_idle_release: assert property ((ssi_idle && i_protocol_variant_select) [*8]
        |=> o_serial_output_oe_n)
        else $error("three-wire idle output not released");
    a_mode_off_quiet: assert property ((i_interface_family_select_pin
        && i_protocol_variant_select && i_ce) [*8] |=> o_serial_output_oe_n)
        else $error("serial output driven in an unselected mode");
    a_wr_hold_stall: assert property (o_wr_valid && !i_wr_ready && i_ce
        |=> o_wr_valid && $stable(o_wr))
        else $error("write request changed while stalled");
    a_ovf_sticky: assert property (o_wr_overflow && !i_overflow_clear
        |=> o_wr_overflow)
        else $error("overflow flag dropped without clear");
    a_ovf_clear: assert property (i_overflow_clear && i_ce && i_frame_strobe_pin
        && $past(i_frame_strobe_pin, 4) |=> !o_wr_overflow)
        else $error("overflow flag not cleared");
    a_wr_quiet: assert property ((!o_wr_valid && i_frame_strobe_pin && i_ce) [*6]
        |=> !o_wr_valid)
        else $error("write request raised outside a frame");
endmodule // esp_port_chk
`default_nettype wire

// [tb/esp_ctl_model.sv]
// Controller model: frame strobe, link clock and command bits for the port
`default_nettype none
module esp_ctl_model (
    // Pins towards the port
    output logic o_strobe,
    output logic o_sclk,
    output logic o_sdi,
    // Reply line as resolved on the board
    input wire logic i_sdo
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle: no frame, link clock parked
    initial
    begin
        o_strobe = 1'b1;
        o_sclk = 1'b0;
        o_sdi = 1'b0;
    end
    // One frame of n bits, MSB first; replies are sampled late in the clock-high half of each bit
    // so the bit launched by the port's synchronised edge has long settled
    task automatic frame(input logic idle, input int n, input logic [39:0] din,
        output logic [39:0] dout);
        dout = '0;
        o_sclk = idle;
        #400 o_strobe = 1'b0;
        #400;
        for (int i = 0; i < n; i++)
        begin
            o_sdi = din[n - 1 - i];
            #200 o_sclk = ~idle;
            #199 if (!idle) dout = {dout[38:0], i_sdo};
            #1 o_sclk = idle;
            #199 if (idle) dout = {dout[38:0], i_sdo};
            #1;
        end
        #200 o_strobe = 1'b1;
        o_sdi = ~o_sdi; // Released line shows no stale bit
        #400;
    endtask
endmodule // esp_ctl_model
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the encoder serial position port
`default_nettype none
module tb import esp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // Clock, reset, configuration and sensor values
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic family = 1'b1, strap = 1'b0, variant = 1'b0, safety = 1'b0;
    logic [1:0] fmt = FMT_SPI8;
    logic [4:0] res = 5'h10;
    logic [17:0] pos = 18'h2_ABCD;
    esp_status_type st = 8'hA5;
    logic warn = 1'b1, err = 1'b0, wr_ready = 1'b0, ovf_clr = 1'b0;
    // Pins and port outputs
    logic strobe, sclk, sdi, out, oe_n, wr_valid, ovf;
    logic [7:0] rd_addr;
    esp_wr_type wr;
    logic [39:0] d;
    int fail_count = 0, compares = 0;
    // Board wire and a register file whose data is its address scrambled
    wire logic sdo = oe_n ? 1'bz : out;
    wire logic [7:0] rd_data = rd_addr ^ 8'h5A;
    // 20 MHz clock
    always #25 clk = ~clk;

    esp_port i_dut (.i_mclk(clk), .i_srst(srst), .i_ce(1'b1), .i_frame_strobe_pin(strobe),
        .i_serial_clock_pin(sclk), .i_serial_input_pin(sdi), .o_serial_output_pin(out),
        .o_serial_output_oe_n(oe_n), .i_interface_family_select_pin(family),
        .i_mode_strap_pin(strap), .i_protocol_variant_select(variant),
        .i_spi_frame_format_select(fmt), .i_resolution(res), .i_safety_format(safety),
        .i_crc16_select(1'b0), .i_crc_init(16'h5555), .i_seq_init(8'hFF),
        .i_position(pos), .i_status(st), .i_warning(warn), .i_error(err),
        .o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_wr_valid(wr_valid), .o_wr(wr),
        .i_wr_ready(wr_ready), .o_wr_overflow(ovf), .i_overflow_clear(ovf_clr));
    esp_ctl_model i_ctl (.o_strobe(strobe), .o_sclk(sclk), .o_sdi(sdi), .i_sdo(sdo));

    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic reset_dut;
        srst = 1'b1;
        repeat (6) tick;
        srst = 1'b0;
        repeat (6) tick;
    endtask
    // Plain MSB-first checksum, initial value is the low byte of the configured seed
    function automatic logic [7:0] crc8(input logic [15:0] v);
        logic [7:0] c;
        c = 8'h55;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? CRC8_POLY : 8'h00);
        return c;
    endfunction
    // Bounded wait for a write request
    task automatic wait_wr;
        for (int i = 0; wr_valid !== 1'b1; i++)
            if (i == 100)
            begin
                fail_count++;
                final_report;
            end
            else
                tick;
    endtask

    // Byte mode position: safety counter from its seed with wrap, then two and three bytes
    task automatic spi8_pos;
        safety = 1'b1;
        reset_dut;
        i_ctl.frame(1'b0, 40, {OP_POS_READ, 32'h0}, d);
        check(d, {8'h00, pos[15:0], st, 8'hFF});
        i_ctl.frame(1'b0, 40, {OP_POS_READ, 32'h0}, d);
        check(d, {8'h00, pos[15:0], st, 8'h01});
        safety = 1'b0;
        i_ctl.frame(1'b0, 32, {OP_POS_READ, 24'h0}, d);
        check(d[31:0], {8'h00, pos[15:0], st});
        res = 5'h11;
        i_ctl.frame(1'b0, 40, {OP_POS_READ, 32'h0}, d);
        check(d, {8'h00, pos[16:0], 7'h00, st});
        res = 5'h10;
        check(sdo, 1'bz);
    endtask
    // Burst write with the consumer stalled: two land, the third overflows
    task automatic spi8_write;
        wr_ready = 1'b0;
        i_ctl.frame(1'b0, 40, {OP_REG_WRITE, 32'h105A_A53C}, d);
        check(d[15:0], 16'h5AA5);
        check(ovf, 1'b1);
        wr_ready = 1'b1;
        wait_wr;
        check(wr, 16'h105A);
        tick;
        wait_wr;
        check(wr, 16'h11A5);
        tick;
        check(wr_valid, 1'b0);
        ovf_clr = 1'b1;
        tick;
        ovf_clr = 1'b0;
        tick;
        check(ovf, 1'b0);
    endtask
    // Burst read, then the same link with the variant select that turns it off
    task automatic spi8_read;
        i_ctl.frame(1'b0, 32, {OP_REG_READ, 8'h20, 16'h0}, d);
        check(d[15:0], {8'h20 ^ 8'h5A, 8'h21 ^ 8'h5A});
        variant = 1'b1;
        repeat (4) tick;
        i_ctl.frame(1'b0, 32, {OP_POS_READ, 24'h0}, d);
        check(d[31:0], {32{1'bz}});
        variant = 1'b0;
    endtask
    // Framed link: each reply answers the previous command; the first after reset is the position
    task automatic spi24;
        logic [15:0] r;
        fmt = FMT_SPI24;
        res = 5'h0C;
        reset_dut;
        r = {warn, err, pos[11:0], 2'b00};
        i_ctl.frame(1'b0, 24, {16'h4020, crc8(16'h4020)}, d);
        check(d[23:0], {r, crc8(r)});
        i_ctl.frame(1'b0, 24, {16'h403F, crc8(16'h403F)}, d);
        check(d[23:0], {warn, err, 6'h00, 8'h20 ^ 8'h5A, crc8({warn, err, 6'h00, 8'h7A})});
        i_ctl.frame(1'b0, 24, {16'h4020, crc8(16'h4020)}, d);
        check(d[23:0], {r, crc8(r)});
    endtask
    // Three-wire read with both idle behaviours of the output
    task automatic ssi3;
        logic [18:0] v;
        family = 1'b0;
        strap = 1'b1;
        reset_dut;
        repeat (4) tick;
        check({out, oe_n}, 2'b10);
        v = {pos[11:0], st.ready[1], st[5:0]};
        i_ctl.frame(1'b1, 20, 40'h0, d);
        check(d[19:0], {v, ^v});
        variant = 1'b1;
        repeat (8) tick;
        check(oe_n, 1'b1);
    endtask

    // Main sequence
    initial
    begin
        reset_dut;
        check({oe_n, out, wr_valid, ovf, rd_addr}, {4'b1100, ADDR_RESET});
        spi8_pos;
        spi8_write;
        spi8_read;
        spi24;
        ssi3;
        final_report;
    end
    // Hang guard far above the longest run
    initial
    begin
        repeat (100000) @(posedge clk);
        fail_count++;
        final_report;
    end
endmodule // tb

bind esp_port esp_port_chk i_chk (.i_mclk, .i_srst, .i_ce, .i_frame_strobe_pin,
    .i_interface_family_select_pin, .i_mode_strap_pin, .i_protocol_variant_select,
    .o_serial_output_pin, .o_serial_output_oe_n, .o_rd_addr, .o_wr_valid, .o_wr,
    .i_wr_ready, .o_wr_overflow, .i_overflow_clear);
`default_nettype wire
